// *** src/tw_pkg.sv ***
// constants, types and register map of the 8-bit waveform timer
package tw_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [11:0] TW_CTRL_OFF = 12'h000;
   localparam logic [11:0] TW_CNT_OFF = 12'h004;
   localparam logic [11:0] TW_CMP_OFF = 12'h008;
   localparam logic [11:0] TW_STAT_OFF = 12'h00c;

   // ----------------------------------------------------------------
   // control fields
   // ----------------------------------------------------------------
   localparam int TW_MODE_LSB = 0;
   localparam int TW_ACT_LSB = 4;
   localparam int TW_FORCE_BIT = 7;
   localparam int TW_DDR_BIT = 8;
   localparam int TW_PORT_BIT = 9;

   // status fields, write one to clear the flags
   localparam int TW_OVF_BIT = 0;
   localparam int TW_CMF_BIT = 1;
   localparam int TW_WAVE_BIT = 2;
   localparam int TW_DIR_BIT = 3;

   // ----------------------------------------------------------------
   // counter values and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] TW_BOTTOM = 8'h00;
   localparam logic [7:0] TW_MAX = 8'hff;
   localparam logic [7:0] TW_ONE = 8'h01;
   localparam logic [7:0] TW_CMP_RST = 8'h00;
   localparam logic [31:0] TW_ZERO_WORD = 32'h0000_0000;

   typedef enum logic [1:0] {
      TW_WM_NORMAL = 2'b00,
      TW_WM_PHASE = 2'b01,
      TW_WM_CTC = 2'b10,
      TW_WM_FAST = 2'b11
   } tw_mode_t;

   typedef enum logic [1:0] {
      TW_ACT_NONE = 2'b00,
      TW_ACT_TOGGLE = 2'b01,
      TW_ACT_CLEAR = 2'b10,
      TW_ACT_SET = 2'b11
   } tw_act_t;

endpackage : tw_pkg

// *** src/tw_timer.sv ***
// 8-bit timer with one compare channel, four waveform modes, apb registers
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module tw_timer
   import tw_pkg::*;
(
   input wire logic mclk_i,
   input wire logic srst_i,
   input wire logic tmr_tick_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   output logic waveform_output_o,
   output logic waveform_output_oe_n_o,
   output logic overflow_flag_o,
   output logic compare_match_flag_o
);

   // ----------------------------------------------------------------
   // apb slave
   // ----------------------------------------------------------------
   // one wait state: pready rises in the second access cycle
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic hit;
   logic wr_en;
   logic wr_ctrl;
   logic wr_cnt;
   logic wr_cmp;
   logic wr_stat;

   tw_mode_t waveform_mode_select;
   tw_act_t compare_output_action;
   logic pin_dir_out;
   logic port_level;
   logic [7:0] counter_value;
   logic count_up;
   logic [7:0] compare_value_reg;
   logic [7:0] compare_buf;
   logic match_block;
   logic overflow_flag;
   logic compare_match_flag;
   logic wave;

   always_comb
   begin
      hit = (paddr_i == TW_CTRL_OFF) || (paddr_i == TW_CNT_OFF) ||
            (paddr_i == TW_CMP_OFF) || (paddr_i == TW_STAT_OFF);
      wr_en = psel_i && penable_i && pready_o && pwrite_i && hit;
      wr_ctrl = wr_en && (paddr_i == TW_CTRL_OFF);
      wr_cnt = wr_en && (paddr_i == TW_CNT_OFF);
      wr_cmp = wr_en && (paddr_i == TW_CMP_OFF);
      wr_stat = wr_en && (paddr_i == TW_STAT_OFF);
      next_pready = psel_i && penable_i && !pready_o;
      next_pslverr = next_pready && !hit;
      next_prdata = prdata_o;
      if (next_pready && !pwrite_i)
      begin
         next_prdata = TW_ZERO_WORD;
         case (paddr_i)
            TW_CTRL_OFF:
            begin
               // force strobe always reads zero
               next_prdata[TW_MODE_LSB +: 2] = waveform_mode_select;
               next_prdata[TW_ACT_LSB +: 2] = compare_output_action;
               next_prdata[TW_DDR_BIT] = pin_dir_out;
               next_prdata[TW_PORT_BIT] = port_level;
            end
            TW_CNT_OFF: next_prdata[7:0] = counter_value;
            TW_CMP_OFF: next_prdata[7:0] = compare_buf;
            TW_STAT_OFF:
            begin
               next_prdata[TW_OVF_BIT] = overflow_flag;
               next_prdata[TW_CMF_BIT] = compare_match_flag;
               next_prdata[TW_WAVE_BIT] = wave;
               next_prdata[TW_DIR_BIT] = count_up;
            end
            default: next_prdata = TW_ZERO_WORD;
         endcase
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         prdata_o <= TW_ZERO_WORD;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end
      else
      begin
         prdata_o <= next_prdata;
         pready_o <= next_pready;
         pslverr_o <= next_pslverr;
      end
   end

   // ----------------------------------------------------------------
   // configuration
   // ----------------------------------------------------------------
   tw_mode_t next_mode;
   tw_act_t next_act;
   logic next_dir_out;
   logic next_port;
   logic pwm_mode;
   logic force_now;

   always_comb
   begin
      next_mode = waveform_mode_select;
      next_act = compare_output_action;
      next_dir_out = pin_dir_out;
      next_port = port_level;
      if (wr_ctrl)
      begin
         next_mode = tw_mode_t'(pwdata_i[TW_MODE_LSB +: 2]);
         next_act = tw_act_t'(pwdata_i[TW_ACT_LSB +: 2]);
         next_dir_out = pwdata_i[TW_DDR_BIT];
         next_port = pwdata_i[TW_PORT_BIT];
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         waveform_mode_select <= TW_WM_NORMAL;
         compare_output_action <= TW_ACT_NONE;
         pin_dir_out <= 1'b0;
         port_level <= 1'b0;
      end
      else
      begin
         waveform_mode_select <= next_mode;
         compare_output_action <= next_act;
         pin_dir_out <= next_dir_out;
         port_level <= next_port;
      end
   end

   // ----------------------------------------------------------------
   // counter unit and compare register
   // ----------------------------------------------------------------
   // the sequence depends on the mode only, never on the action
   logic [7:0] next_cnt;
   logic next_up;
   logic [7:0] next_ocr;
   logic [7:0] next_buf;
   logic next_block;
   logic at_max;
   logic at_bottom;
   logic match;

   always_comb
   begin
      pwm_mode = (waveform_mode_select == TW_WM_FAST) || (waveform_mode_select == TW_WM_PHASE);
      at_max = (counter_value == TW_MAX);
      at_bottom = (counter_value == TW_BOTTOM);
      // a counter write masks the match of the following tick
      match = tmr_tick_i && !match_block && (counter_value == compare_value_reg);
      next_cnt = counter_value;
      next_up = count_up;
      next_ocr = compare_value_reg;
      next_buf = compare_buf;
      next_block = match_block;
      if (tmr_tick_i)
      begin
         next_block = 1'b0;
         case (waveform_mode_select)
            TW_WM_NORMAL:
            begin
               next_cnt = counter_value + TW_ONE; // wraps FF to 00
               next_up = 1'b1;
            end
            TW_WM_CTC:
            begin
               next_up = 1'b1;
               if (match)
                  next_cnt = TW_BOTTOM;
               else
                  next_cnt = counter_value + TW_ONE; // a missed top runs on to MAX and wraps
            end
            TW_WM_FAST:
            begin
               next_up = 1'b1;
               next_cnt = counter_value + TW_ONE; // MAX is followed by BOTTOM
               if (at_max)
                  next_ocr = compare_buf; // reload at the wrap
            end
            TW_WM_PHASE:
            begin
               // full eight-bit turning points
               if (count_up && at_max)
               begin
                  next_up = 1'b0; // MAX seen once, then down
                  next_cnt = counter_value - TW_ONE;
                  next_ocr = compare_buf; // reload at top
               end
               else if (!count_up && at_bottom)
               begin
                  next_up = 1'b1;
                  next_cnt = counter_value + TW_ONE;
               end
               else if (count_up)
                  next_cnt = counter_value + TW_ONE;
               else
                  next_cnt = counter_value - TW_ONE;
            end
            default: next_cnt = counter_value;
         endcase
      end
      if (waveform_mode_select != TW_WM_PHASE)
         next_up = 1'b1;
      if (wr_cmp)
      begin
         next_buf = pwdata_i[7:0];
         // non-pwm writes reach the comparator at once
         if (!pwm_mode)
            next_ocr = pwdata_i[7:0];
      end
      // software write overrides any count or clear
      if (wr_cnt)
      begin
         next_cnt = pwdata_i[7:0];
         next_block = 1'b1;
      end
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         counter_value <= TW_BOTTOM;
         count_up <= 1'b1;
         compare_value_reg <= TW_CMP_RST;
         compare_buf <= TW_CMP_RST;
         match_block <= 1'b0;
      end
      else
      begin
         counter_value <= next_cnt;
         count_up <= next_up;
         compare_value_reg <= next_ocr;
         compare_buf <= next_buf;
         match_block <= next_block;
      end
   end

   // ----------------------------------------------------------------
   // flags
   // ----------------------------------------------------------------
   // set beats a software clear in the same cycle
   logic next_ovf;
   logic next_cmf;
   logic ovf_set;

   always_comb
   begin
      ovf_set = 1'b0;
      if (tmr_tick_i && !wr_cnt)
      begin
         case (waveform_mode_select)
            TW_WM_NORMAL: ovf_set = at_max; // counter becomes zero
            TW_WM_CTC: ovf_set = at_max && (next_cnt == TW_BOTTOM);
            TW_WM_FAST: ovf_set = at_max;
            TW_WM_PHASE: ovf_set = at_bottom;
            default: ovf_set = 1'b0;
         endcase
      end
      next_ovf = (overflow_flag && !(wr_stat && pwdata_i[TW_OVF_BIT])) || ovf_set;
      next_cmf = (compare_match_flag && !(wr_stat && pwdata_i[TW_CMF_BIT])) || match;
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         overflow_flag <= 1'b0;
         compare_match_flag <= 1'b0;
      end
      else
      begin
         overflow_flag <= next_ovf;
         compare_match_flag <= next_cmf;
      end
   end

   // ----------------------------------------------------------------
   // waveform generator and pin
   // ----------------------------------------------------------------
   logic next_wave;
   logic next_pin;
   logic next_oe_n;
   logic up_phase;
   tw_act_t force_act;

   always_comb
   begin
      // at the turning points the match counts as the far slope
      if (at_bottom)
         up_phase = 1'b1;
      else if (at_max)
         up_phase = 1'b0;
      else
         up_phase = count_up;
      force_act = tw_act_t'(pwdata_i[TW_ACT_LSB +: 2]);
      force_now = wr_ctrl && pwdata_i[TW_FORCE_BIT] &&
                  (tw_mode_t'(pwdata_i[TW_MODE_LSB +: 2]) != TW_WM_FAST) &&
                  (tw_mode_t'(pwdata_i[TW_MODE_LSB +: 2]) != TW_WM_PHASE);
      next_wave = wave;
      case (waveform_mode_select)
         TW_WM_NORMAL, TW_WM_CTC:
         begin
            if (force_now)
            begin
               // forced action uses the setting written with it
               case (force_act)
                  TW_ACT_TOGGLE: next_wave = !wave;
                  TW_ACT_CLEAR: next_wave = 1'b0;
                  TW_ACT_SET: next_wave = 1'b1;
                  default: next_wave = wave;
               endcase
            end
            else if (match)
            begin
               case (compare_output_action)
                  TW_ACT_TOGGLE: next_wave = !wave;
                  TW_ACT_CLEAR: next_wave = 1'b0;
                  TW_ACT_SET: next_wave = 1'b1;
                  default: next_wave = wave;
               endcase
            end
         end
         TW_WM_FAST:
         begin
            // wrap level wins over a match at MAX: constant output
            if (tmr_tick_i && at_max && compare_output_action == TW_ACT_CLEAR)
               next_wave = 1'b1;
            else if (tmr_tick_i && at_max && compare_output_action == TW_ACT_SET)
               next_wave = 1'b0;
            else if (match)
            begin
               case (compare_output_action)
                  TW_ACT_TOGGLE: next_wave = !wave;
                  TW_ACT_CLEAR: next_wave = 1'b0;
                  TW_ACT_SET: next_wave = 1'b1;
                  default: next_wave = wave;
               endcase
            end
         end
         TW_WM_PHASE:
         begin
            if (match)
            begin
               case (compare_output_action)
                  TW_ACT_CLEAR: next_wave = !up_phase;
                  TW_ACT_SET: next_wave = up_phase;
                  default: next_wave = wave; // toggle reserved here
               endcase
            end
         end
         default: next_wave = wave;
      endcase
      // action zero hands the pin back to the port latch
      if (compare_output_action == TW_ACT_NONE)
         next_pin = port_level;
      else
         next_pin = next_wave;
      next_oe_n = !pin_dir_out;
   end

   always_ff @(posedge mclk_i)
   begin
      if (srst_i)
      begin
         wave <= 1'b0;
         waveform_output_o <= 1'b0;
         waveform_output_oe_n_o <= 1'b1;
         overflow_flag_o <= 1'b0;
         compare_match_flag_o <= 1'b0;
      end
      else
      begin
         wave <= next_wave;
         waveform_output_o <= next_pin;
         waveform_output_oe_n_o <= next_oe_n;
         overflow_flag_o <= next_ovf;
         compare_match_flag_o <= next_cmf;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (srst_i);

   a_action_zero_hold: assert property (
      (compare_output_action == TW_ACT_NONE && !force_now) |=> $stable(wave))
      else $error("waveform changed with action zero");

   a_normal_wrap: assert property (
      (tmr_tick_i && waveform_mode_select == TW_WM_NORMAL && at_max && !wr_cnt)
      |=> (counter_value == TW_BOTTOM) && overflow_flag)
      else $error("normal mode did not wrap with overflow");

   a_ctc_top_clear: assert property (
      (waveform_mode_select == TW_WM_CTC && match && !wr_cnt)
      |=> (counter_value == TW_BOTTOM) && compare_match_flag)
      else $error("clear-on-compare did not clear at match");

   a_ctc_toggle: assert property (
      (waveform_mode_select == TW_WM_CTC && match && !force_now && compare_output_action == TW_ACT_TOGGLE)
      |=> wave != $past(wave))
      else $error("toggle missing at compare match");

   a_fast_ovf_max: assert property (
      (tmr_tick_i && waveform_mode_select == TW_WM_FAST && at_max && !wr_cnt)
      |=> overflow_flag && counter_value == TW_BOTTOM)
      else $error("fast mode overflow not set at MAX");

   a_fast_bottom_set: assert property (
      (tmr_tick_i && waveform_mode_select == TW_WM_FAST && at_max && compare_output_action == TW_ACT_CLEAR)
      |=> wave && waveform_output_o)
      else $error("non-inverting fast output not set at wrap");

   a_phase_top_turn: assert property (
      (tmr_tick_i && waveform_mode_select == TW_WM_PHASE && count_up && at_max && !wr_cnt && !wr_ctrl)
      |=> !count_up && counter_value == (TW_MAX - TW_ONE))
      else $error("phase-correct did not turn at MAX");

   a_phase_ovf_bottom: assert property (
      (tmr_tick_i && waveform_mode_select == TW_WM_PHASE && at_bottom && !wr_cnt)
      |=> overflow_flag)
      else $error("phase-correct overflow not set at zero");

   a_pwm_buffered: assert property (
      (wr_cmp && pwm_mode && !tmr_tick_i) |=> compare_value_reg == $past(compare_value_reg))
      else $error("pwm compare write bypassed the buffer");

   a_pin_direction: assert property (
      pin_dir_out |=> !waveform_output_oe_n_o)
      else $error("pin not driven while direction is output");

endmodule : tw_timer

// *** sim/tb_top.sv ***
// self-checking bench of the 8-bit waveform timer, driven over apb
`timescale 1ns/100ps
module tb_top
   import tw_pkg::*;
;
   logic mclk_i = 1'b0;
   logic srst_i = 1'b1;
   logic tmr_tick_i = 1'b0;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0000_0000;
   logic [31:0] prdata_o;
   logic pready_o;
   logic pslverr_o;
   logic waveform_output_o;
   logic waveform_output_oe_n_o;
   logic overflow_flag_o;
   logic compare_match_flag_o;
   logic [31:0] rdv;
   logic erv;
   int n_fail = 0;
   int comparisons = 0;
   int cyc = 0;

   tw_timer dut (.mclk_i(mclk_i), .srst_i(srst_i), .tmr_tick_i(tmr_tick_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .waveform_output_o(waveform_output_o), .waveform_output_oe_n_o(waveform_output_oe_n_o),
      .overflow_flag_o(overflow_flag_o), .compare_match_flag_o(compare_match_flag_o));

   initial
   begin
      forever #20 mclk_i = ~mclk_i;
   end

   // ----------------------------------------------------------------
   // shared helpers
   // ----------------------------------------------------------------
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
      begin
         $display("Finished cleanly");
      end
      else
      begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e)
      begin
         $display("wrong value %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask : chk

   // request held until pready is sampled high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk_i);
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge mclk_i);
      penable_i <= 1'b1;
      k = 0;
      do
      begin
         @(posedge mclk_i);
         k++;
      end
      while (pready_o !== 1'b1 && k < 20);
      if (k >= 20)
      begin
         $display("wrong value pready expected 1 seen 0");
         n_fail++;
         end_sim();
      end
      else
      begin
         rdv = prdata_o;
         erv = pslverr_o;
         psel_i <= 1'b0;
         penable_i <= 1'b0;
      end
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr

   task automatic rd(input logic [11:0] a);
      apb(1'b0, a, 32'h0000_0000);
   endtask : rd

   // tick held high for exactly n clock edges
   task automatic tick(input int n);
      @(posedge mclk_i);
      tmr_tick_i <= 1'b1;
      repeat (n) @(posedge mclk_i);
      tmr_tick_i <= 1'b0;
   endtask : tick

   task automatic st(input string nm, input int b, input logic e);
      rd(TW_STAT_OFF);
      chk(nm, e, rdv[b]);
   endtask : st

   function automatic logic [31:0] ctl(input tw_mode_t m, input tw_act_t a, input logic f, input logic p);
      logic [31:0] v;
      v = TW_ZERO_WORD;
      v[TW_MODE_LSB +: 2] = m;
      v[TW_ACT_LSB +: 2] = a;
      v[TW_FORCE_BIT] = f;
      v[TW_DDR_BIT] = 1'b1;
      v[TW_PORT_BIT] = p;
      return v;
   endfunction : ctl

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      chk("pin", 32'h0, waveform_output_o);
      chk("oe_n", 32'h1, waveform_output_oe_n_o);
      rd(TW_CTRL_OFF);
      chk("ctrl", TW_ZERO_WORD, rdv);
      rd(TW_CMP_OFF);
      chk("compare", {24'h0, TW_CMP_RST}, rdv);
      rd(TW_STAT_OFF);
      chk("status", 32'h8, rdv);
      rd(12'h010);
      chk("unmapped err", 32'h1, erv);
      chk("unmapped data", TW_ZERO_WORD, rdv);
      $display("test reset done");
   endtask : t_reset

   task automatic t_force();
      wr(TW_CTRL_OFF, ctl(TW_WM_NORMAL, TW_ACT_SET, 1'b1, 1'b0));
      st("forced set", TW_WAVE_BIT, 1'b1);
      chk("pin set", 32'h1, waveform_output_o);
      chk("oe_n on", 32'h0, waveform_output_oe_n_o);
      wr(TW_CTRL_OFF, ctl(TW_WM_NORMAL, TW_ACT_CLEAR, 1'b1, 1'b0));
      st("forced clear", TW_WAVE_BIT, 1'b0);
      // action zero: the pin falls back to the port latch
      wr(TW_CTRL_OFF, ctl(TW_WM_NORMAL, TW_ACT_NONE, 1'b1, 1'b1));
      st("force none", TW_WAVE_BIT, 1'b0);
      chk("pin port", 32'h1, waveform_output_o);
      wr(TW_CTRL_OFF, TW_ZERO_WORD);
      repeat (2) @(posedge mclk_i);
      chk("oe_n off", 32'h1, waveform_output_oe_n_o);
      $display("test force done");
   endtask : t_force

   task automatic t_normal();
      wr(TW_CNT_OFF, 32'h0000_00fe);
      tick(2);
      rd(TW_CNT_OFF);
      chk("wrap count", 32'h0, rdv);
      chk("ovf port", 32'h1, overflow_flag_o);
      tick(1);
      rd(TW_CNT_OFF);
      chk("after wrap", 32'h1, rdv);
      st("ovf kept", TW_OVF_BIT, 1'b1);
      wr(TW_STAT_OFF, 32'h3);
      st("ovf cleared", TW_OVF_BIT, 1'b0);
      $display("test normal done");
   endtask : t_normal

   task automatic t_ctc();
      wr(TW_CMP_OFF, 32'h3);
      wr(TW_CTRL_OFF, ctl(TW_WM_CTC, TW_ACT_TOGGLE, 1'b0, 1'b0));
      wr(TW_CNT_OFF, 32'h0);
      tick(4);
      rd(TW_CNT_OFF);
      chk("ctc top", 32'h0, rdv);
      rd(TW_STAT_OFF);
      chk("ctc toggle", 32'h1, rdv[TW_WAVE_BIT]);
      chk("ctc match", 32'h1, rdv[TW_CMF_BIT]);
      chk("ctc no ovf", 32'h0, rdv[TW_OVF_BIT]);
      chk("pin toggle", 32'h1, waveform_output_o);
      chk("cmf port", 32'h1, compare_match_flag_o);
      wr(TW_CTRL_OFF, ctl(TW_WM_CTC, TW_ACT_NONE, 1'b0, 1'b0));
      tick(4);
      st("none keeps", TW_WAVE_BIT, 1'b1);
      // compare written below the count: match missed until wrap
      wr(TW_CTRL_OFF, ctl(TW_WM_CTC, TW_ACT_TOGGLE, 1'b0, 1'b0));
      wr(TW_CNT_OFF, 32'h10);
      wr(TW_CMP_OFF, 32'h5);
      wr(TW_STAT_OFF, 32'h3);
      tick(239);
      rd(TW_CNT_OFF);
      chk("run to max", 32'hff, rdv);
      st("no early match", TW_CMF_BIT, 1'b0);
      tick(1);
      st("ovf max wrap", TW_OVF_BIT, 1'b1);
      tick(6);
      rd(TW_STAT_OFF);
      chk("late match", 32'h1, rdv[TW_CMF_BIT]);
      chk("late toggle", 32'h0, rdv[TW_WAVE_BIT]);
      $display("test ctc done");
   endtask : t_ctc

   task automatic t_fast();
      tw_act_t acts[2];
      logic inv;
      acts[0] = TW_ACT_CLEAR;
      acts[1] = TW_ACT_SET;
      wr(TW_CTRL_OFF, TW_ZERO_WORD);
      wr(TW_CMP_OFF, 32'h80);
      foreach (acts[i])
      begin
         inv = (acts[i] == TW_ACT_SET);
         wr(TW_CTRL_OFF, ctl(TW_WM_FAST, acts[i], 1'b0, 1'b0));
         wr(TW_STAT_OFF, 32'h3);
         wr(TW_CNT_OFF, 32'hfe);
         tick(1);
         rd(TW_CNT_OFF);
         chk("fast max", 32'hff, rdv);
         tick(1);
         rd(TW_CNT_OFF);
         chk("fast clear", 32'h0, rdv);
         rd(TW_STAT_OFF);
         chk("fast ovf", 32'h1, rdv[TW_OVF_BIT]);
         chk("wrap level", {31'h0, ~inv}, rdv[TW_WAVE_BIT]);
         wr(TW_CNT_OFF, 32'h7e);
         tick(3);
         rd(TW_STAT_OFF);
         chk("match level", {31'h0, inv}, rdv[TW_WAVE_BIT]);
         chk("fast match", 32'h1, rdv[TW_CMF_BIT]);
      end
      // new compare waits in the buffer until the wrap
      wr(TW_STAT_OFF, 32'h3);
      wr(TW_CMP_OFF, 32'h84);
      tick(4);
      st("buffered", TW_CMF_BIT, 1'b0);
      rd(TW_CMP_OFF);
      chk("buffer read", 32'h84, rdv);
      // toggle in fast mode, with the buffered compare loaded at the wrap
      wr(TW_CTRL_OFF, ctl(TW_WM_FAST, TW_ACT_TOGGLE, 1'b0, 1'b0));
      wr(TW_CNT_OFF, 32'hff);
      tick(1);
      wr(TW_CNT_OFF, 32'h83);
      tick(2);
      st("fast toggle", TW_WAVE_BIT, 1'b0);
      // compare zero: one timer cycle high after the wrap
      wr(TW_CMP_OFF, 32'h0);
      wr(TW_CTRL_OFF, ctl(TW_WM_FAST, TW_ACT_CLEAR, 1'b0, 1'b0));
      wr(TW_CNT_OFF, 32'hff);
      tick(1);
      st("spike high", TW_WAVE_BIT, 1'b1);
      tick(1);
      st("spike end", TW_WAVE_BIT, 1'b0);
      $display("test fast done");
   endtask : t_fast

   task automatic t_phase();
      wr(TW_CTRL_OFF, TW_ZERO_WORD);
      wr(TW_CMP_OFF, 32'h80);
      // start from a low level so that the down-slope set is visible
      wr(TW_CTRL_OFF, ctl(TW_WM_NORMAL, TW_ACT_CLEAR, 1'b1, 1'b0));
      st("phase start low", TW_WAVE_BIT, 1'b0);
      wr(TW_CTRL_OFF, ctl(TW_WM_PHASE, TW_ACT_CLEAR, 1'b0, 1'b0));
      wr(TW_CNT_OFF, 32'hfd);
      tick(2);
      rd(TW_CNT_OFF);
      chk("phase top", 32'hff, rdv);
      tick(1);
      rd(TW_CNT_OFF);
      chk("phase turn", 32'hfe, rdv);
      st("dir down", TW_DIR_BIT, 1'b0);
      wr(TW_CNT_OFF, 32'h82);
      tick(3);
      st("down match set", TW_WAVE_BIT, 1'b1);
      wr(TW_CNT_OFF, 32'h2);
      wr(TW_STAT_OFF, 32'h3);
      tick(2);
      rd(TW_CNT_OFF);
      chk("bottom", 32'h0, rdv);
      tick(1);
      rd(TW_STAT_OFF);
      chk("phase ovf", 32'h1, rdv[TW_OVF_BIT]);
      chk("dir up", 32'h1, rdv[TW_DIR_BIT]);
      rd(TW_CNT_OFF);
      chk("climb", 32'h1, rdv);
      wr(TW_CNT_OFF, 32'h7e);
      tick(3);
      st("up match clear", TW_WAVE_BIT, 1'b0);
      $display("test phase done");
   endtask : t_phase

   // ----------------------------------------------------------------
   // sequence and hang guard
   // ----------------------------------------------------------------
   always @(posedge mclk_i)
   begin
      cyc++;
      // whole run needs well under 4000 cycles
      if (cyc == 20000)
      begin
         n_fail++;
         end_sim();
      end
   end

   initial
   begin
      repeat (16) @(posedge mclk_i);
      srst_i <= 1'b0;
      @(posedge mclk_i);
      t_reset();
      t_force();
      t_normal();
      t_ctc();
      t_fast();
      t_phase();
      end_sim();
   end
endmodule : tb_top
